// ### design/psm_ctrl.sv
`timescale 1ns/1ps
module psm_ctrl (
  input  wire logic                          core_clk,       // System clock, 100 MHz.
  input  wire logic                          nrst,           // Asynchronous reset, active low.
  input  wire logic [3:0]                    avs_address,    // Byte address.
  input  wire logic                          avs_read,       // Read request.
  input  wire logic                          avs_write,      // Write request.
  input  wire logic [31:0]                   avs_writedata,  // Write data.
  input  wire logic [3:0]                    avs_byteenable, // Byte lanes.
  output logic [31:0]                        avs_readdata,   // Read data.
  output logic                               avs_waitrequest,// Stall.
  input  wire psm_pkg::psm_instr_s           instr,          // Power-save instruction.
  input  wire logic                          irq_wake,       // Enabled irq meeting priority.
  input  wire logic                          wdt_timeout,    // Watchdog time-out pulse.
  input  wire logic                          por_evt,        // Power-on reset event.
  input  wire logic                          brownout_reset_evt, // Brown-out reset event.
  input  wire logic                          master_clear_pin,   // Reset pin level, active high.
  input  wire logic                          pll_locked,     // PLL lock, async.
  input  wire logic                          osc_running,    // Crystal running, async.
  input  wire logic [2:0]                    primary_osc_family_cfg, // Config source.
  input  wire logic [4:0]                    primary_osc_mode_cfg,   // Config mode.
  input  wire logic [psm_pkg::NUM_PERIPH-1:0] periph_present, // Variant has peripheral.
  output psm_pkg::psm_clk_s                  clk_ctl,        // Clock gating controls.
  output logic [psm_pkg::NUM_PERIPH-1:0]     periph_en,      // Peripheral clock enables.
  output logic [psm_pkg::NUM_PERIPH-1:0]     periph_reg_en,  // Peripheral register access.
  output logic                               resume_pulse,   // CPU resumes after wake.
  output logic                               reset_wake      // Wake was by reset.
);

  psm_pkg::psm_state_e state;
  psm_pkg::psm_state_e next_state;
  logic [31:0]                   ctrl;
  logic [4:0]                    reset_control_reg;
  logic [15:0]                   mdis;
  logic [15:0]                   mdis_d;
  logic [2:0]                    current_osc_select;
  logic [psm_pkg::WAKE_CNT_W-1:0] wake_cnt;
  logic [psm_pkg::WAKE_CNT_W-1:0] next_wake_cnt;
  logic [2:0]                    master_clear_pin_sync;
  logic [2:0]                    lock_sync;
  logic [2:0]                    run_sync;
  logic                          master_clear_pin_q;
  logic                          any_reset;
  logic                          wake_evt;
  logic                          from_sleep;
  logic                          rd_q;
  logic                          lock_ok;
  logic                          osc_ok;
  logic                          fail_trap;

  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    be_merge = old;
    if (be[0]) begin
      be_merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      be_merge[15:8] = wd[15:8];
    end
  endfunction

  function automatic logic is_crystal(input logic [2:0] src);
    is_crystal = (src == psm_pkg::OSC_XTAL);
  endfunction

  // Three-stage synchronisers; a change counts once stages two and three agree.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      master_clear_pin_sync <= 3'h0;
      lock_sync <= 3'h0;
      run_sync  <= 3'h0;
      master_clear_pin_q    <= 1'b0;
      lock_ok   <= 1'b0;
      osc_ok    <= 1'b0;
    end else begin
      master_clear_pin_sync <= {master_clear_pin_sync[1:0], master_clear_pin};
      lock_sync <= {lock_sync[1:0], pll_locked};
      run_sync  <= {run_sync[1:0], osc_running};
      if (master_clear_pin_sync[1] == master_clear_pin_sync[2]) begin
        master_clear_pin_q <= master_clear_pin_sync[2];
      end
      if (lock_sync[1] == lock_sync[2]) begin
        lock_ok <= lock_sync[2];
      end
      if (run_sync[1] == run_sync[2]) begin
        osc_ok <= run_sync[2];
      end
    end
  end

  assign any_reset = por_evt | brownout_reset_evt | master_clear_pin_q;
  assign wake_evt  = irq_wake | wdt_timeout | any_reset;
  assign from_sleep = (state == psm_pkg::PSM_SLEEP);

  // Wake delay length chosen from the clock being restarted.
  function automatic logic [psm_pkg::WAKE_CNT_W-1:0] wake_len(input logic [2:0] src,
                                                             input logic lp_on);
    if (is_crystal(src)) begin
      wake_len = psm_pkg::WAKE_CNT_W'(psm_pkg::PWRT_CYC + psm_pkg::OST_CYC);
    end else if (src == psm_pkg::OSC_LPX && !lp_on) begin
      wake_len = psm_pkg::WAKE_CNT_W'(psm_pkg::PWRT_CYC + psm_pkg::OST_CYC);
    end else begin
      wake_len = psm_pkg::WAKE_CNT_W'(psm_pkg::POR_CYC);
    end
  endfunction

  always_comb begin
    next_state    = state;
    next_wake_cnt = wake_cnt;
    case (state)
      psm_pkg::PSM_RUN: begin
        if (instr.req && !wake_evt) begin
          next_state = instr.sleep ? psm_pkg::PSM_SLEEP : psm_pkg::PSM_IDLE;
        end
      end
      psm_pkg::PSM_IDLE: begin
        if (wake_evt) begin
          next_state = psm_pkg::PSM_RUN;
        end
      end
      psm_pkg::PSM_SLEEP: begin
        if (wake_evt) begin
          next_state    = psm_pkg::PSM_WAKE;
          next_wake_cnt = wake_len(current_osc_select, ctrl[psm_pkg::CTL_LPON]);
        end
      end
      psm_pkg::PSM_WAKE: begin
        if (wake_cnt != '0) begin
          next_wake_cnt = wake_cnt - 1'b1;
        end else if (is_crystal(current_osc_select) &&
                     (!osc_ok || (ctrl[psm_pkg::CTL_PLLEN] && !lock_ok))) begin
          next_state = ctrl[psm_pkg::CTL_CFME] ? psm_pkg::PSM_RUN : psm_pkg::PSM_HOLD;
        end else begin
          next_state = psm_pkg::PSM_RUN;
        end
      end
      psm_pkg::PSM_HOLD: begin
        if (osc_ok && (!ctrl[psm_pkg::CTL_PLLEN] || lock_ok)) begin
          next_state = psm_pkg::PSM_RUN;
        end
      end
      default: begin
        next_state = psm_pkg::PSM_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state    <= psm_pkg::PSM_RUN;
      wake_cnt <= '0;
    end else begin
      state    <= next_state;
      wake_cnt <= next_wake_cnt;
    end
  end

  // Clock-failure trap forces fast RC until software writes the oscillator register.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fail_trap <= 1'b0;
    end else if (state == psm_pkg::PSM_WAKE && next_state == psm_pkg::PSM_RUN &&
                 wake_cnt == '0 && ctrl[psm_pkg::CTL_CFME] && is_crystal(current_osc_select) &&
                 (!osc_ok || (ctrl[psm_pkg::CTL_PLLEN] && !lock_ok))) begin
      fail_trap <= 1'b1;
    end else if (avs_write && !avs_waitrequest && avs_address == psm_pkg::OSC_OFS) begin
      fail_trap <= 1'b0;
    end
  end

  // Oscillator select: software switches when enabled; POR/BOR reload from config.
  // A software write beats the trap's fast RC force, so that the very write that
  // clears the trap can also re-enable the crystal instead of being lost.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      current_osc_select <= psm_pkg::OSC_FRC;
    end else if (por_evt || brownout_reset_evt) begin
      current_osc_select <= primary_osc_family_cfg ^ {2'h0, ^primary_osc_mode_cfg};
    end else if (avs_write && !avs_waitrequest && avs_address == psm_pkg::OSC_OFS &&
                 ctrl[psm_pkg::CTL_CLKSW] && avs_byteenable[0]) begin
      current_osc_select <= avs_writedata[2:0];
    end else if (fail_trap) begin
      current_osc_select <= psm_pkg::OSC_FRC;
    end
  end

  // Status flags: hardware sets win over software clears.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reset_control_reg <= 5'h0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == psm_pkg::STATUS_OFS &&
          avs_byteenable[0]) begin
        reset_control_reg <= reset_control_reg & ~avs_writedata[4:0];
      end
      if ((state == psm_pkg::PSM_SLEEP) && wake_evt && !por_evt) begin
        reset_control_reg[psm_pkg::RC_SLEEP] <= 1'b1;
      end
      if ((state == psm_pkg::PSM_IDLE) && wake_evt && !por_evt) begin
        reset_control_reg[psm_pkg::RC_IDLE] <= 1'b1;
      end
      if ((from_sleep || state == psm_pkg::PSM_IDLE) && wdt_timeout &&
          ctrl[psm_pkg::CTL_WDTEN]) begin
        reset_control_reg[psm_pkg::RC_WATCHDOG_TIMEOUT_FLAG] <= 1'b1;
      end
      if (brownout_reset_evt) begin
        reset_control_reg[psm_pkg::RC_BOR] <= 1'b1;
      end
      if (por_evt) begin
        reset_control_reg <= 5'h0;
        reset_control_reg[psm_pkg::RC_POR] <= 1'b1;
        reset_control_reg[psm_pkg::RC_BOR] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= psm_pkg::CTRL_RST;
    end else if (avs_write && !avs_waitrequest && avs_address == psm_pkg::CTRL_OFS) begin
      ctrl[15:0] <= be_merge(ctrl[15:0], avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mdis   <= psm_pkg::MDIS_RST;
      mdis_d <= psm_pkg::MDIS_RST;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == psm_pkg::MDIS_OFS) begin
        mdis <= be_merge(mdis, avs_writedata, avs_byteenable);
      end
      mdis_d <= mdis;
    end
  end

  // Peripheral clocks: one gate per module.
  genvar gi;
  generate
    for (gi = 0; gi < psm_pkg::NUM_PERIPH; gi++) begin : g_periph
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          periph_en[gi]     <= 1'b0;
          periph_reg_en[gi] <= 1'b0;
        end else begin
          periph_reg_en[gi] <= periph_present[gi] & ~mdis_d[gi];
          periph_en[gi]     <= periph_present[gi] & ~mdis_d[gi] &
                               (next_state == psm_pkg::PSM_RUN ||
                                next_state == psm_pkg::PSM_IDLE);
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk_ctl      <= '0;
      resume_pulse <= 1'b0;
      reset_wake   <= 1'b0;
      rd_q         <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      clk_ctl.cpu_clk_en    <= (next_state == psm_pkg::PSM_RUN);
      clk_ctl.periph_clk_en <= (next_state == psm_pkg::PSM_RUN) ||
                               (next_state == psm_pkg::PSM_IDLE);
      clk_ctl.osc_en        <= (next_state != psm_pkg::PSM_SLEEP) ||
                               (current_osc_select == psm_pkg::OSC_LPX &&
                                ctrl[psm_pkg::CTL_LPON]);
      clk_ctl.low_power_rc_osc_en       <= (next_state != psm_pkg::PSM_SLEEP) ||
                               ctrl[psm_pkg::CTL_WDTEN];
      clk_ctl.cfm_active    <= ctrl[psm_pkg::CTL_CFME] &&
                               (next_state != psm_pkg::PSM_SLEEP);
      clk_ctl.bor_active    <= ctrl[psm_pkg::CTL_BOREN];
      clk_ctl.lvd_active    <= ctrl[psm_pkg::CTL_LVDEN];
      clk_ctl.fast_rc_force <= fail_trap;
      clk_ctl.clk_fail_trap <= fail_trap;
      resume_pulse <= (state != psm_pkg::PSM_RUN) && (next_state == psm_pkg::PSM_RUN);
      reset_wake   <= (state != psm_pkg::PSM_RUN) && any_reset;
      rd_q <= avs_read && !rd_q;
      if (avs_read && !rd_q) begin
        case (avs_address)
          psm_pkg::CTRL_OFS:   avs_readdata <= ctrl;
          psm_pkg::STATUS_OFS: avs_readdata <= {27'h0, reset_control_reg};
          psm_pkg::MDIS_OFS:   avs_readdata <= {16'h0, mdis};
          psm_pkg::OSC_OFS:    avs_readdata <= {24'h0, state != psm_pkg::PSM_RUN,
                                                fail_trap, lock_ok, osc_ok, 1'b0,
                                                current_osc_select};
          default:             avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // Reads take one wait cycle so read data come from a flip-flop.
  assign avs_waitrequest = avs_read && !rd_q;

endmodule

// ### design/psm_pkg.sv
package psm_pkg;

  // Avalon-MM register word offsets (byte addresses).
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] MDIS_OFS   = 4'h8;
  localparam logic [3:0] OSC_OFS    = 4'hc;

  // Number of peripheral module-disable bits.
  localparam int NUM_PERIPH = 16;

  // Fields of the reset control image (status register).
  localparam int RC_POR   = 0;
  localparam int RC_BOR   = 1;
  localparam int RC_IDLE  = 2;
  localparam int RC_SLEEP = 3;
  localparam int RC_WATCHDOG_TIMEOUT_FLAG  = 4;

  // Fields of the control register.
  localparam int CTL_CLKSW = 0;
  localparam int CTL_CFME  = 1;
  localparam int CTL_WDTEN = 2;
  localparam int CTL_BOREN = 3;
  localparam int CTL_LVDEN = 4;
  localparam int CTL_PLLEN = 5;
  localparam int CTL_LPON  = 6;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] MDIS_RST = 16'h0000;

  // Oscillator source codes for current_osc_select.
  localparam logic [2:0] OSC_EXT  = 3'h0;
  localparam logic [2:0] OSC_FRC  = 3'h1;
  localparam logic [2:0] OSC_LOW_POWER_RC_OSC = 3'h2;
  localparam logic [2:0] OSC_ERC  = 3'h3;
  localparam logic [2:0] OSC_LPX  = 3'h4;
  localparam logic [2:0] OSC_XTAL = 3'h5;

  // Wake delays.
  localparam int CLK_MHZ        = 100;
  localparam int POR_DELAY_US   = 10;
  localparam int POR_CYC        = POR_DELAY_US * CLK_MHZ;
  localparam int PWRT_DELAY_US  = 64;
  localparam int PWRT_CYC       = PWRT_DELAY_US * CLK_MHZ;
  localparam int OST_CYC        = 1024;
  localparam int WAKE_CNT_W     = 16;

  typedef enum logic [4:0] {
    PSM_RUN   = 5'b00001,
    PSM_IDLE  = 5'b00010,
    PSM_SLEEP = 5'b00100,
    PSM_WAKE  = 5'b01000,
    PSM_HOLD  = 5'b10000
  } psm_state_e;

  typedef struct packed {
    logic       req;   // Power-save instruction executed.
    logic       sleep; // Operand: 1 selects Sleep, 0 selects Idle.
  } psm_instr_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic low_power_rc_osc_en;
    logic cfm_active;
    logic bor_active;
    logic lvd_active;
    logic fast_rc_force;
    logic clk_fail_trap;
  } psm_clk_s;

endpackage

// ### sim/psm_core_model.sv
`timescale 1ns/1ps
module psm_core_model #(
  parameter int START = 64
) (
  input  wire logic              core_clk,    // Clock.
  input  wire logic              nrst,        // Reset, active low.
  input  wire logic              go_req,      // Issue the instruction.
  input  wire logic              go_sleep,    // Operand to issue.
  input  wire logic              xtal_dead,   // Crystal fails to start.
  input  wire psm_pkg::psm_clk_s clk_ctl,     // Clock controls.
  output psm_pkg::psm_instr_s    instr,       // Executed instruction.
  output logic                   osc_running, // Crystal stable.
  output logic                   pll_locked   // PLL locked.
);
  int cnt;

  // The instruction retires in one cycle, so its request is a single pulse.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      instr <= '0;
    end else begin
      instr.req   <= go_req;
      instr.sleep <= go_sleep;
    end
  end

  // A gated crystal clears its count at once and reports not running one cycle later, not holding its last state.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt         <= 0;
      osc_running <= 1'b0;
      pll_locked  <= 1'b0;
    end else begin
      cnt         <= (!clk_ctl.osc_en || xtal_dead) ? 0 : (cnt < START ? cnt + 1 : cnt);
      osc_running <= cnt >= START;
      pll_locked  <= osc_running;
    end
  end
endmodule

// ### sim/psm_ctrl_asserts.sv
`timescale 1ns/1ps
module psm_ctrl_asserts (
  input wire logic                core_clk,         // Clock.
  input wire logic                nrst,             // Reset, active low.
  input wire logic [3:0]          avs_address,      // Bus address.
  input wire logic                avs_write,        // Bus write.
  input wire logic [31:0]         avs_writedata,    // Bus data.
  input wire logic [3:0]          avs_byteenable,   // Bus lanes.
  input wire psm_pkg::psm_instr_s instr,            // Instruction.
  input wire logic                irq_wake,         // Interrupt wake.
  input wire logic                wdt_timeout,      // Watchdog time-out.
  input wire logic                por_evt,          // Power-on event.
  input wire logic                master_clear_pin, // Reset pin.
  input wire logic [15:0]         periph_present,   // Variant map.
  input wire psm_pkg::psm_clk_s   clk_ctl,          // Clock controls.
  input wire logic [15:0]         periph_en,        // Peripheral clocks.
  input wire logic [15:0]         periph_reg_en     // Register access.
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  logic run_ok;
  logic in_sleep;
  // Entry is only judged when no irq, watchdog, POR or raw reset-pin input competes with it.
  assign run_ok   = clk_ctl.cpu_clk_en && !irq_wake && !wdt_timeout && !por_evt
                    && !master_clear_pin;
  assign in_sleep = !clk_ctl.cpu_clk_en && !clk_ctl.periph_clk_en;

  a_idle_entry: assert property (
    instr.req && !instr.sleep && run_ok |=> !clk_ctl.cpu_clk_en && clk_ctl.periph_clk_en)
    else $error("idle entry gated the wrong clocks");
  a_sleep_entry: assert property (
    instr.req && instr.sleep && run_ok |=> in_sleep && !clk_ctl.cfm_active
      && $stable(clk_ctl.bor_active) && $stable(clk_ctl.lvd_active))
    else $error("sleep entry gated the wrong clocks");
  a_idle_wake_now: assert property (
    !clk_ctl.cpu_clk_en && clk_ctl.periph_clk_en && (irq_wake || wdt_timeout)
      |=> clk_ctl.cpu_clk_en)
    else $error("idle wake was not immediate");
  a_entry_race: assert property (
    instr.req && clk_ctl.cpu_clk_en && (irq_wake || wdt_timeout) |=> clk_ctl.cpu_clk_en [*2])
    else $error("cpu clock stopped despite a wake event");
  a_sleep_delay: assert property (
    in_sleep && (irq_wake || wdt_timeout) |=> !clk_ctl.cpu_clk_en [*8])
    else $error("sleep wake skipped its start-up delay");
  a_absent_off: assert property (
    ((periph_en | periph_reg_en) & ~periph_present) == 16'h0000)
    else $error("absent peripheral enabled");
  a_mdis_apply: assert property (
    avs_write && avs_address == psm_pkg::MDIS_OFS && avs_byteenable == 4'h3
      ##1 !(avs_write && avs_address == psm_pkg::MDIS_OFS) [*3]
      |-> !clk_ctl.cpu_clk_en || {periph_en, periph_reg_en}
          == {2{periph_present & ~$past(avs_writedata[15:0], 3)}})
    else $error("module disable not applied");
  a_trap_fast: assert property (
    clk_ctl.clk_fail_trap |-> clk_ctl.fast_rc_force)
    else $error("clock trap without fast rc");

  c_sleep: cover property (instr.req && instr.sleep ##1 in_sleep);
  c_trap: cover property ($rose(clk_ctl.clk_fail_trap));
  c_idle: cover property (!clk_ctl.cpu_clk_en && clk_ctl.periph_clk_en ##1 clk_ctl.cpu_clk_en);
endmodule

bind psm_ctrl psm_ctrl_asserts chk (.core_clk, .nrst, .avs_address, .avs_write, .avs_writedata,
  .avs_byteenable, .instr, .irq_wake, .wdt_timeout, .por_evt, .master_clear_pin,
  .periph_present, .clk_ctl, .periph_en, .periph_reg_en);

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                core_clk, nrst, avs_read, avs_write, avs_waitrequest, irq_wake;
  logic                wdt_timeout, por_evt, master_clear_pin, go_req, go_sleep, xtal_dead;
  logic                osc_running, pll_locked, resume_pulse, reset_wake, rw_seen;
  logic [3:0]          avs_address;
  logic [31:0]         avs_writedata, avs_readdata, v;
  logic [15:0]         periph_en, periph_reg_en;
  psm_pkg::psm_instr_s instr;
  psm_pkg::psm_clk_s   clk_ctl;
  int                  errors, comparisons, n;
  localparam logic [15:0] PRESENT = 16'h7fff;
  logic [3:0]          ofs [3] = '{psm_pkg::CTRL_OFS, psm_pkg::MDIS_OFS, 4'h2};
  logic [31:0]         ctl [3] = '{32'h1d, 32'h3f, 32'h5d};
  logic [2:0]          src [3] = '{psm_pkg::OSC_EXT, psm_pkg::OSC_XTAL, psm_pkg::OSC_LPX};
  int                  dly [3] = '{psm_pkg::POR_CYC, psm_pkg::PWRT_CYC + psm_pkg::OST_CYC,
                                   psm_pkg::POR_CYC};

  psm_ctrl uut (.core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .instr, .irq_wake, .wdt_timeout,
    .por_evt, .brownout_reset_evt(1'b0), .master_clear_pin, .pll_locked, .osc_running,
    .primary_osc_family_cfg(3'h0), .primary_osc_mode_cfg(5'h00), .periph_present(PRESENT),
    .clk_ctl, .periph_en, .periph_reg_en, .resume_pulse, .reset_wake);
  psm_core_model model (.core_clk, .nrst, .go_req, .go_sleep, .xtal_dead, .clk_ctl, .instr,
    .osc_running, .pll_locked);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (reset_wake === 1'b1) rw_seen <= 1'b1;
  initial begin
    #1000000;
    errors++;
    test_done();
  end

  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // The request is held until the edge at which waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    v = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic pwr(input logic s);
    @(posedge core_clk);
    go_req   <= 1'b1;
    go_sleep <= s;
    @(posedge core_clk);
    go_req <= 1'b0;
    cyc(3);
  endtask
  task automatic kick(input int k);
    @(posedge core_clk);
    irq_wake    <= (k == 0);
    wdt_timeout <= (k == 1);
    @(posedge core_clk);
    irq_wake    <= 1'b0;
    wdt_timeout <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic waken();
    n = 0;
    while (clk_ctl.cpu_clk_en !== 1'b1) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic st(input logic [2:0] e);
    bus(1'b0, psm_pkg::STATUS_OFS, 32'h0);
    chk(v[4:2], e);
    bus(1'b1, psm_pkg::STATUS_OFS, 32'h1f);
  endtask

  initial begin
    {nrst, avs_read, avs_write, irq_wake, wdt_timeout, por_evt} = '0;
    {master_clear_pin, go_req, go_sleep, xtal_dead, rw_seen, avs_address, avs_writedata} = '0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    cyc(2);
    chk({clk_ctl.cpu_clk_en, periph_en, periph_reg_en}, {1'b1, PRESENT, PRESENT});
    bus(1'b1, 4'h2, 32'h0000ffff);
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 32'h0);
      chk(v, 32'h0);
    end
    bus(1'b1, psm_pkg::MDIS_OFS, 32'hffff0003);
    cyc(3);
    chk({periph_en, periph_reg_en}, {2{PRESENT & 16'hfffc}});
    bus(1'b0, psm_pkg::MDIS_OFS, 32'h0);
    chk(v, 32'h3);
    bus(1'b1, psm_pkg::MDIS_OFS, 32'h0);
    cyc(3);
    chk(periph_en, PRESENT);
    bus(1'b1, psm_pkg::CTRL_OFS, 32'h1d);
    for (int k = 0; k < 2; k++) begin
      pwr(1'b0);
      chk({clk_ctl.cpu_clk_en, clk_ctl.periph_clk_en, clk_ctl.osc_en}, 3'b011);
      kick(k);
      chk({clk_ctl.cpu_clk_en, resume_pulse}, 2'b11);
      st(k ? 3'b101 : 3'b001);
    end
    @(posedge core_clk);
    go_req <= 1'b1;
    @(posedge core_clk);
    go_req   <= 1'b0;
    irq_wake <= 1'b1;
    @(posedge core_clk);
    irq_wake <= 1'b0;
    cyc(2);
    chk(clk_ctl.cpu_clk_en, 1'b1);
    bus(1'b1, psm_pkg::STATUS_OFS, 32'h1f);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, psm_pkg::CTRL_OFS, ctl[k]);
      bus(1'b1, psm_pkg::OSC_OFS, {29'h0, src[k]});
      cyc(100);
      pwr(1'b1);
      if (k == 1) chk(clk_ctl[8:1], 8'h16);
      kick(k == 1);
      waken();
      chk(n >= dly[k] - 1 && n <= dly[k] + 4, 1'b1);
      st(k == 1 ? 3'b110 : 3'b010);
      bus(1'b0, psm_pkg::OSC_OFS, 32'h0);
      chk(v[2:0], src[k]);
    end
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, psm_pkg::CTRL_OFS, k ? 32'h3d : 32'h3f);
      bus(1'b1, psm_pkg::OSC_OFS, {29'h0, psm_pkg::OSC_XTAL});
      pwr(1'b1);
      xtal_dead <= 1'b1;
      kick(0);
      cyc(psm_pkg::PWRT_CYC + psm_pkg::OST_CYC + 20);
      chk({clk_ctl.clk_fail_trap, clk_ctl.fast_rc_force, clk_ctl.cpu_clk_en}, k ? 0 : 7);
      bus(1'b0, psm_pkg::OSC_OFS, 32'h0);
      chk(v[6], !k);
      xtal_dead <= 1'b0;
      bus(1'b1, psm_pkg::OSC_OFS, 32'h5);
      waken();
      st(3'b010);
    end
    for (int k = 0; k < 2; k++) begin
      rw_seen = 1'b0;
      pwr(k[0]);
      @(posedge core_clk);
      master_clear_pin <= 1'b1;
      repeat (8) @(posedge core_clk);
      master_clear_pin <= 1'b0;
      waken();
      chk(rw_seen, 1'b1);
      st(k ? 3'b010 : 3'b001);
    end
    pwr(1'b0);
    kick(0);
    @(posedge core_clk);
    por_evt <= 1'b1;
    @(posedge core_clk);
    por_evt <= 1'b0;
    waken();
    bus(1'b0, psm_pkg::STATUS_OFS, 32'h0);
    chk(v[4:0], 5'h03);
    bus(1'b0, psm_pkg::OSC_OFS, 32'h0);
    chk(v[2:0], psm_pkg::OSC_EXT);
    test_done();
  end
endmodule
